// ===== design/dsra_map.svh
// Constants for the dual serial register access slave.
`ifndef DSRA_MAP_SVH
`define DSRA_MAP_SVH
`define DSRA_IDX_W       7
`define DSRA_TGT_ADDR_HI 6'h14
`define DSRA_BYTE_LAST   3'h7
`define DSRA_TW_BITS     4'h8
`define DSRA_PIN_N       4
`define DSRA_PIN_CLK     0
`define DSRA_PIN_DAT     1
`define DSRA_PIN_CS      2
`define DSRA_PIN_SA      3
`define DSRA_FPH_IDLE    2'h0
`define DSRA_FPH_ISSUE   2'h1
`define DSRA_FPH_CAP     2'h3
`endif

// ===== design/dsra_pkg.sv
// Types shared by the dual serial register access slave.
package dsra_pkg;
  // Two-wire engine states, one-hot.
  typedef enum logic [8:0]
  {
    TW_IDLE = 9'h001,
    TW_ADDR = 9'h002,
    TW_AACK = 9'h004,
    TW_SUB  = 9'h008,
    TW_SACK = 9'h010,
    TW_WR   = 9'h020,
    TW_WACK = 9'h040,
    TW_RD   = 9'h080,
    TW_MACK = 9'h100
  } dsra_tw_e;
  // Phase of a register fetch.
  typedef logic [1:0] dsra_fph_t;
endpackage

// ===== design/dsra_pins_if.sv
// Interface carrying synchronised pin levels and their edges.
`timescale 1ns/1ps
`default_nettype none
interface dsra_pins_if #(parameter int N = 4);
  logic [N-1:0] lvl;
  logic [N-1:0] rise;
  logic [N-1:0] fall;
  modport src (output lvl, output rise, output fall);
  modport dst (input lvl, input rise, input fall);
endinterface
`default_nettype wire

// ===== design/dsra_pin_sync.sv
// Two-flop synchroniser with edge detection for the serial pins.
`timescale 1ns/1ps
`default_nettype none
`include "dsra_map.svh"
module dsra_pin_sync
  import dsra_pkg::*;
#(
  parameter int N = `DSRA_PIN_N
)
(
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic [N-1:0] raw,
  dsra_pins_if.src          pins
);
  logic [N-1:0] meta_r;
  logic [N-1:0] lvl_r;
  logic [N-1:0] last_r;

  // Idle bus lines sit high, so the chain resets high to avoid false edges.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_r <= '1;
      lvl_r  <= '1;
      last_r <= '1;
    end
    else
    begin
      meta_r <= raw;
      lvl_r  <= meta_r;
      last_r <= lvl_r;
    end
  end

  // Only the second and third stages feed the edge detectors.
  assign pins.lvl  = lvl_r;
  assign pins.rise = lvl_r & ~last_r;
  assign pins.fall = ~lvl_r & last_r;
endmodule
`default_nettype wire

// ===== design/dsra_reg_ptr.sv
// Register pointer with load and optional auto increment.
`timescale 1ns/1ps
`default_nettype none
`include "dsra_map.svh"
module dsra_reg_ptr
  import dsra_pkg::*;
#(
  parameter int IDX_W = `DSRA_IDX_W
)
(
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             load,
  input  wire logic [IDX_W-1:0] load_idx,
  input  wire logic             load_inc,
  input  wire logic             step,
  output logic      [IDX_W-1:0] idx
);
  logic inc_r;

  // A load wins over a step; a step only moves when increment is on.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      idx   <= '0;
      inc_r <= 1'b0;
    end
    else if (load)
    begin
      idx   <= load_idx;
      inc_r <= load_inc;
    end
    else if (step && inc_r)
    begin
      idx <= idx + 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== design/dsra_top.sv
// Serial slave giving two-wire or SPI access to 8-bit internal registers.
`timescale 1ns/1ps
`default_nettype none
`include "dsra_map.svh"
module dsra_top
  import dsra_pkg::*;
#(
  parameter int IDX_W = `DSRA_IDX_W
)
(
  input  wire logic             sys_clk,
  input  wire logic             arst_n,
  input  wire logic             chip_select_n,
  input  wire logic             serial_port_clock_i,
  output logic                  serial_port_clock_o,
  output logic                  serial_port_clock_oe,
  input  wire logic             serial_in_line_i,
  output logic                  serial_in_line_o,
  output logic                  serial_in_line_oe,
  output logic                  serial_out_line_o,
  output logic                  serial_out_line_oe,
  input  wire logic             addr_select_pin,
  input  wire logic             three_wire_select,
  output logic      [IDX_W-1:0] reg_index,
  output logic      [7:0]       reg_wdata,
  output logic                  reg_wr_stb,
  output logic                  reg_rd_stb,
  input  wire logic [7:0]       reg_rdata,
  output logic                  bus_busy
);
  dsra_pins_if #(.N(`DSRA_PIN_N)) pin_bus ();

  dsra_tw_e         tw_st_r;
  logic [7:0]       sh_r;
  logic [7:0]       tx_r;
  logic [7:0]       rbuf_r;
  logic [3:0]       bit_r;
  logic             rw_r;
  logic             hdr_r;
  logic             more_r;
  logic             hold_r;
  logic             fdone_r;
  dsra_fph_t        fph_r;
  logic [IDX_W-1:0] ptr;
  logic             clk_rise;
  logic             clk_fall;
  logic             din;
  logic             cs_lvl;
  logic             tw_on;
  logic             start_ev;
  logic             stop_ev;
  logic             byte_end;
  logic             spi_hdr_end;
  logic             spi_blk_end;
  logic             spi_bit;
  logic             tw_fall8;
  logic             fetch_req;
  logic             wr_req;
  logic [7:0]       wr_data;
  logic             ptr_load;
  logic [IDX_W-1:0] ptr_load_idx;
  logic             ptr_load_inc;
  logic             ptr_step;

  // Every pin from the host except three_wire_select passes two flops before use.
  dsra_pin_sync #(.N(`DSRA_PIN_N)) u_sync
  (
    .clk    (sys_clk),
    .arst_n (arst_n),
    .raw    ({addr_select_pin, chip_select_n, serial_in_line_i, serial_port_clock_i}),
    .pins   (pin_bus)
  );

  dsra_reg_ptr #(.IDX_W(IDX_W)) u_ptr
  (
    .clk      (sys_clk),
    .arst_n   (arst_n),
    .load     (ptr_load),
    .load_idx (ptr_load_idx),
    .load_inc (ptr_load_inc),
    .step     (ptr_step),
    .idx      (ptr)
  );

  // Select high means two-wire mode, select low means SPI.
  assign cs_lvl   = pin_bus.lvl[`DSRA_PIN_CS];
  assign tw_on    = cs_lvl;
  assign clk_rise = pin_bus.rise[`DSRA_PIN_CLK];
  assign clk_fall = pin_bus.fall[`DSRA_PIN_CLK];
  assign din      = pin_bus.lvl[`DSRA_PIN_DAT];

  // Bus conditions are data edges while the clock stays high.
  assign start_ev = tw_on && pin_bus.lvl[`DSRA_PIN_CLK] && pin_bus.fall[`DSRA_PIN_DAT];
  assign stop_ev  = tw_on && pin_bus.lvl[`DSRA_PIN_CLK] && pin_bus.rise[`DSRA_PIN_DAT];

  // SPI framing: the eighth rising edge of each block closes it.
  assign byte_end    = !tw_on && clk_rise && (bit_r[2:0] == `DSRA_BYTE_LAST);
  assign spi_hdr_end = byte_end && !hdr_r;
  assign spi_blk_end = byte_end && hdr_r;
  assign spi_bit     = (bit_r[2:0] == 3'h0) ? rbuf_r[7] : tx_r[7];
  assign tw_fall8    = tw_on && !start_ev && !stop_ev && clk_fall && (bit_r == `DSRA_TW_BITS);

  // Register requests coming from either engine.
  always_comb
  begin
    fetch_req    = 1'b0;
    wr_req       = 1'b0;
    wr_data      = sh_r;
    ptr_load     = 1'b0;
    ptr_load_idx = {1'b0, sh_r[4:0], din};
    ptr_load_inc = sh_r[5];
    ptr_step     = 1'b0;
    if (!tw_on)
    begin
      if (spi_hdr_end)
      begin
        ptr_load  = 1'b1;
        fetch_req = sh_r[6];
      end
      if (spi_blk_end)
      begin
        ptr_step  = 1'b1;
        fetch_req = rw_r;
        wr_req    = !rw_r;
        wr_data   = {sh_r[6:0], din};
      end
    end
    else if (!start_ev && !stop_ev)
    begin
      if (tw_st_r == TW_SUB && tw_fall8)
      begin
        ptr_load     = 1'b1;
        ptr_load_idx = sh_r[IDX_W-1:0];
        ptr_load_inc = sh_r[7];
      end
      if (tw_st_r == TW_WR && tw_fall8)
      begin
        wr_req   = 1'b1;
        ptr_step = 1'b1;
      end
      if (tw_st_r == TW_RD && tw_fall8 && !hold_r)
      begin
        ptr_step = 1'b1;
      end
      if (clk_fall && ((tw_st_r == TW_AACK && rw_r) || (tw_st_r == TW_MACK && more_r)))
      begin
        fetch_req = 1'b1;
      end
    end
  end

  // Register fetch: strobe, then capture the returned byte.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fph_r      <= `DSRA_FPH_IDLE;
      reg_rd_stb <= 1'b0;
      rbuf_r     <= 8'h00;
      fdone_r    <= 1'b0;
    end
    else
    begin
      reg_rd_stb <= (fph_r == `DSRA_FPH_ISSUE);
      fdone_r    <= (fph_r == `DSRA_FPH_CAP);
      if (fetch_req)
      begin
        fph_r <= `DSRA_FPH_ISSUE;
      end
      else if (fph_r != `DSRA_FPH_IDLE)
      begin
        fph_r <= fph_r + 2'h1;
      end
      if (fph_r == `DSRA_FPH_CAP)
      begin
        rbuf_r <= reg_rdata;
      end
    end
  end

  // Register port: index and write data are held until the next access.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reg_index  <= '0;
      reg_wdata  <= 8'h00;
      reg_wr_stb <= 1'b0;
    end
    else
    begin
      reg_wr_stb <= wr_req;
      if (wr_req)
      begin
        reg_index <= ptr;
        reg_wdata <= wr_data;
      end
      else if (fph_r == `DSRA_FPH_ISSUE)
      begin
        reg_index <= ptr;
      end
    end
  end

  // Busy from start to stop; leaving two-wire mode frees the bus too.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bus_busy <= 1'b0;
    end
    else if (start_ev)
    begin
      bus_busy <= 1'b1;
    end
    else if (stop_ev || !tw_on)
    begin
      bus_busy <= 1'b0;
    end
  end

  // Serial engine for both modes; pad drivers are set here directly.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tw_st_r              <= TW_IDLE;
      sh_r                 <= 8'h00;
      tx_r                 <= 8'h00;
      bit_r                <= 4'h0;
      rw_r                 <= 1'b0;
      hdr_r                <= 1'b0;
      more_r               <= 1'b0;
      hold_r               <= 1'b0;
      serial_in_line_o     <= 1'b0;
      serial_in_line_oe    <= 1'b0;
      serial_out_line_o    <= 1'b0;
      serial_out_line_oe   <= 1'b0;
      serial_port_clock_o  <= 1'b0;
      serial_port_clock_oe <= 1'b0;
    end
    else if (!tw_on)
    begin
      tw_st_r              <= TW_IDLE;
      hold_r               <= 1'b0;
      serial_port_clock_oe <= 1'b0;
      if (pin_bus.fall[`DSRA_PIN_CS])
      begin
        bit_r              <= 4'h0;
        hdr_r              <= 1'b0;
        serial_in_line_oe  <= 1'b0;
        serial_out_line_oe <= 1'b0;
      end
      else
      begin
        // Sample on the rising edge.
        if (clk_rise)
        begin
          sh_r  <= {sh_r[6:0], din};
          bit_r <= {1'b0, bit_r[2:0] + 3'h1};
          if (spi_hdr_end)
          begin
            hdr_r <= 1'b1;
            rw_r  <= sh_r[6];
          end
        end
        // Read data changes on the falling edge from bit 8 on.
        if (clk_fall && hdr_r && rw_r)
        begin
          tx_r <= (bit_r[2:0] == 3'h0) ? {rbuf_r[6:0], 1'b0} : {tx_r[6:0], 1'b0};
          if (three_wire_select)
          begin
            serial_in_line_o   <= spi_bit;
            serial_in_line_oe  <= 1'b1;
            serial_out_line_oe <= 1'b0;
          end
          else
          begin
            serial_out_line_o  <= spi_bit;
            serial_out_line_oe <= 1'b1;
            serial_in_line_oe  <= 1'b0;
          end
        end
      end
    end
    else
    begin
      // Two-wire mode: the data pad is open drain, so only low is driven.
      serial_in_line_o   <= 1'b0;
      serial_out_line_oe <= 1'b0;
      if (pin_bus.rise[`DSRA_PIN_CS] || stop_ev)
      begin
        tw_st_r              <= TW_IDLE;
        serial_in_line_oe    <= 1'b0;
        hold_r               <= 1'b0;
        serial_port_clock_oe <= 1'b0;
      end
      else if (start_ev)
      begin
        tw_st_r              <= TW_ADDR;
        bit_r                <= 4'h0;
        serial_in_line_oe    <= 1'b0;
        hold_r               <= 1'b0;
        serial_port_clock_oe <= 1'b0;
      end
      else
      begin
        unique case (tw_st_r)
          TW_IDLE:
          begin
            serial_in_line_oe <= 1'b0;
          end
          TW_ADDR, TW_SUB, TW_WR:
          begin
            if (clk_rise)
            begin
              sh_r  <= {sh_r[6:0], din};
              bit_r <= bit_r + 4'h1;
            end
            else if (tw_fall8)
            begin
              bit_r <= 4'h0;
              if (tw_st_r != TW_ADDR)
              begin
                serial_in_line_oe <= 1'b1;
                tw_st_r <= (tw_st_r == TW_SUB) ? TW_SACK : TW_WACK;
              end
              else if (sh_r[7:1] == {`DSRA_TGT_ADDR_HI, pin_bus.lvl[`DSRA_PIN_SA]})
              begin
                rw_r              <= sh_r[0];
                serial_in_line_oe <= 1'b1;
                tw_st_r           <= TW_AACK;
              end
              else
              begin
                tw_st_r <= TW_IDLE;
              end
            end
          end
          TW_AACK:
          begin
            if (clk_fall)
            begin
              serial_in_line_oe <= 1'b0;
              if (rw_r)
              begin
                hold_r               <= 1'b1;
                serial_port_clock_oe <= 1'b1;
                tw_st_r              <= TW_RD;
              end
              else
              begin
                tw_st_r <= TW_SUB;
              end
            end
          end
          TW_SACK, TW_WACK:
          begin
            if (clk_fall)
            begin
              serial_in_line_oe <= 1'b0;
              tw_st_r           <= TW_WR;
            end
          end
          TW_RD:
          begin
            if (hold_r)
            begin
              if (fdone_r)
              begin
                hold_r               <= 1'b0;
                serial_port_clock_oe <= 1'b0;
                serial_in_line_oe    <= ~rbuf_r[7];
                tx_r                 <= {rbuf_r[6:0], 1'b0};
                bit_r                <= 4'h1;
              end
            end
            else if (tw_fall8)
            begin
              serial_in_line_oe <= 1'b0;
              bit_r             <= 4'h0;
              tw_st_r           <= TW_MACK;
            end
            else if (clk_fall)
            begin
              serial_in_line_oe <= ~tx_r[7];
              tx_r              <= {tx_r[6:0], 1'b0};
              bit_r             <= bit_r + 4'h1;
            end
          end
          TW_MACK:
          begin
            if (clk_rise)
            begin
              more_r <= ~din;
            end
            else if (clk_fall)
            begin
              if (more_r)
              begin
                hold_r               <= 1'b1;
                serial_port_clock_oe <= 1'b1;
                tw_st_r              <= TW_RD;
              end
              else
              begin
                tw_st_r <= TW_IDLE;
              end
            end
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ===== bench/dsra_chk_sva.sv
// Concurrent checks on the ports of the dual serial register access slave.
`timescale 1ns/1ps
`default_nettype none
module dsra_chk
  import dsra_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic chip_select_n,
  input wire logic serial_port_clock_i,
  input wire logic serial_port_clock_o,
  input wire logic serial_port_clock_oe,
  input wire logic serial_in_line_i,
  input wire logic serial_in_line_o,
  input wire logic serial_in_line_oe,
  input wire logic serial_out_line_oe,
  input wire logic three_wire_select,
  input wire logic reg_wr_stb,
  input wire logic reg_rd_stb,
  input wire logic bus_busy
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  // Register strobes are single-cycle pulses.
  a_wr_pulse_once: assert property (reg_wr_stb |=> !reg_wr_stb)
    else $error("write strobe held longer than one cycle");
  a_rd_pulse_once: assert property (reg_rd_stb |=> !reg_rd_stb)
    else $error("read strobe held longer than one cycle");
  // The four-wire output pin stays quiet in three-wire mode and outside frames.
  a_three_wire_quiet: assert property (three_wire_select |-> !serial_out_line_oe)
    else $error("four-wire output driven in three-wire mode");
  a_out_rise_spi: assert property ($rose(serial_out_line_oe) |-> !chip_select_n)
    else $error("four-wire output enabled without a frame");
  // Data outputs are released shortly after select rises.
  a_release_deselect: assert property ($rose(chip_select_n) |-> ##[1:5]
    (!serial_out_line_oe && !serial_in_line_oe))
    else $error("data line still driven after select rose");
  // An SPI frame keeps the two-wire engine idle.
  a_spi_no_tw: assert property (!chip_select_n [*6] |-> !serial_port_clock_oe && !bus_busy)
    else $error("two-wire activity during an SPI frame");
  // Open-drain pins only ever pull low, and a clock stretch ends within 16 cycles.
  a_ack_pulls_low: assert property (
    serial_in_line_oe && chip_select_n && $past(chip_select_n, 6) |-> !serial_in_line_o)
    else $error("two-wire data driven high");
  a_clk_pulls_low: assert property (serial_port_clock_oe |-> !serial_port_clock_o)
    else $error("clock line driven high");
  a_stretch_bound: assert property (
    $rose(serial_port_clock_oe) |-> ##[1:16] !serial_port_clock_oe)
    else $error("clock stretch lasts too long");
  // Start marks the bus busy, stop frees it.
  a_start_busy: assert property (chip_select_n && $past(chip_select_n, 6) &&
    serial_port_clock_i && $fell(serial_in_line_i) |-> ##[2:6] bus_busy)
    else $error("start not flagged busy");
  a_stop_idle: assert property (chip_select_n && $past(chip_select_n, 6) &&
    serial_port_clock_i && $rose(serial_in_line_i) |-> ##[2:6] !bus_busy)
    else $error("stop not flagged idle");

  // Main scenarios reached.
  c_write: cover property (reg_wr_stb);
  c_spi_read: cover property (reg_rd_stb && !chip_select_n);
  c_stretch: cover property ($rose(serial_port_clock_oe));
  c_three_wire: cover property ($rose(serial_in_line_oe) && !chip_select_n);
endmodule
`default_nettype wire

// ===== bench/dsra_host.sv
// Host controller model driving the two-wire bus and the SPI frames.
`timescale 1ns/1ps
`default_nettype none
module dsra_host
  import dsra_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic scl_line,
  input  wire logic sda_line,
  input  wire logic sdo_line,
  output logic      cs_n,
  output logic      h_clk,
  output logic      h_dat,
  output logic      h_oe
);
  localparam int SPI_HALF = 4;
  localparam int TW_Q     = 16;
  logic [7:0] wbuf [3];
  logic [7:0] rbuf [3];
  int         stall_outs = 0;

  // Idle levels: deselected, clock parked high, data released.
  initial
  begin
    cs_n  = 1'b1;
    h_clk = 1'b1;
    h_dat = 1'b1;
    h_oe  = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // One SPI frame: header then n blocks; data changes on falls, sampled late in the high phase.
  task automatic spi(input logic [7:0] hdr, input int n, input logic three);
    logic [7:0] sh;
    cs_n <= 1'b0;
    tick(SPI_HALF);
    for (int b = 0; b <= n; b++)
    begin
      sh = (b == 0) ? hdr : wbuf[b-1];
      for (int i = 7; i >= 0; i--)
      begin
        h_clk <= 1'b0;
        h_dat <= sh[i];
        h_oe  <= !(hdr[7] && b > 0);
        tick(SPI_HALF);
        h_clk <= 1'b1;
        tick(SPI_HALF - 1);
        if (b > 0) rbuf[b-1][i] = three ? sda_line : sdo_line;
        tick(1);
      end
    end
    cs_n <= 1'b1;
    h_oe <= 1'b0;
    tick(2 * SPI_HALF);
  endtask

  // Releases the clock and waits, bounded, while the device stretches it.
  task automatic scl_up();
    int n;
    n = 0;
    h_clk <= 1'b1;
    tick(1);
    while (scl_line !== 1'b1 && n < 64)
    begin
      tick(1);
      n++;
    end
    // A stretch that outlasts the bound is counted for the bench to report.
    if (scl_line !== 1'b1) stall_outs++;
  endtask

  task automatic tw_bit(input logic b, output logic r);
    h_oe <= !b;
    tick(TW_Q);
    scl_up();
    tick(TW_Q);
    r = sda_line;
    tick(TW_Q);
    h_clk <= 1'b0;
    tick(TW_Q);
  endtask

  task automatic tw_start();
    h_oe  <= 1'b0;
    h_dat <= 1'b0;
    tick(TW_Q);
    scl_up();
    tick(TW_Q);
    h_oe <= 1'b1;
    tick(TW_Q);
    h_clk <= 1'b0;
    tick(TW_Q);
  endtask

  task automatic tw_stop();
    h_oe <= 1'b1;
    tick(TW_Q);
    scl_up();
    tick(TW_Q);
    h_oe <= 1'b0;
    tick(TW_Q);
  endtask

  task automatic tw_tx(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) tw_bit(v[i], r);
    tw_bit(1'b1, r);
    ack = !r;
  endtask

  task automatic tw_rx(input logic last, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      tw_bit(1'b1, r);
      v[i] = r;
    end
    tw_bit(last, r);
  endtask
endmodule
`default_nettype wire

// ===== bench/tb_top.sv
// Self-checking bench for the dual serial register access slave.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import dsra_pkg::*;
;
  logic       sys_clk, arst_n, chip_select_n, addr_select_pin, three_wire_select;
  logic       h_clk, h_dat, h_oe, bus_busy, reg_wr_stb, reg_rd_stb;
  logic       serial_port_clock_i, serial_port_clock_o, serial_port_clock_oe;
  logic       serial_in_line_i, serial_in_line_o, serial_in_line_oe;
  logic       serial_out_line_o, serial_out_line_oe, sdo_line;
  logic [6:0] reg_index;
  logic [7:0] reg_wdata, reg_rdata;
  logic [7:0] mem [128];
  logic [7:0] sh [128];
  int         hold = 0;
  int         fails = 0;
  int         comparisons = 0;

  // Clock at 25 MHz.
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Pad levels: open-drain with pull-ups, three-wire data shared with the host.
  assign serial_port_clock_i = serial_port_clock_oe ? serial_port_clock_o : h_clk;
  assign serial_in_line_i    = serial_in_line_oe ? serial_in_line_o : (h_oe ? h_dat : 1'b1);
  assign sdo_line            = serial_out_line_oe ? serial_out_line_o : 1'b1;

  dsra_top i_dsra_top (.sys_clk(sys_clk), .arst_n(arst_n), .chip_select_n(chip_select_n),
    .serial_port_clock_i(serial_port_clock_i), .serial_port_clock_o(serial_port_clock_o),
    .serial_port_clock_oe(serial_port_clock_oe), .serial_in_line_i(serial_in_line_i),
    .serial_in_line_o(serial_in_line_o), .serial_in_line_oe(serial_in_line_oe),
    .serial_out_line_o(serial_out_line_o), .serial_out_line_oe(serial_out_line_oe),
    .addr_select_pin(addr_select_pin), .three_wire_select(three_wire_select),
    .reg_index(reg_index), .reg_wdata(reg_wdata), .reg_wr_stb(reg_wr_stb),
    .reg_rd_stb(reg_rd_stb), .reg_rdata(reg_rdata), .bus_busy(bus_busy));

  dsra_host i_dsra_host (.sys_clk(sys_clk), .scl_line(serial_port_clock_i),
    .sda_line(serial_in_line_i), .sdo_line(sdo_line), .cs_n(chip_select_n),
    .h_clk(h_clk), .h_dat(h_dat), .h_oe(h_oe));

  // Register file: writes land, read data holds two cycles, otherwise noise.
  always @(negedge sys_clk)
  begin
    if (reg_wr_stb === 1'b1) mem[reg_index] <= reg_wdata;
    if (reg_rd_stb === 1'b1)
    begin
      reg_rdata <= mem[reg_index];
      hold <= 2;
    end
    else if (hold != 0) hold <= hold - 1;
    else reg_rdata <= 8'($urandom);
  end

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] want);
    comparisons++;
    if (seen !== want)
    begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, want, seen);
    end
  endtask

  task automatic results();
    $display("comparisons %0d, fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Register touched by block k of a burst.
  function automatic logic [6:0] idx_at(input logic [6:0] base, input logic inc, input int k);
    return inc ? base + 7'(k) : base;
  endfunction

  function automatic logic [7:0] tw_addr(input logic strap, input logic rd);
    return {6'h14, strap, rd};
  endfunction

  // Three-block SPI write then read of the same registers.
  task automatic spi_test(input logic three, input logic inc);
    logic [6:0] a;
    a = 7'($urandom_range(0, 60));
    three_wire_select = three;
    for (int k = 0; k < 3; k++)
    begin
      i_dsra_host.wbuf[k] = 8'($urandom);
      sh[idx_at(a, inc, k)] = i_dsra_host.wbuf[k];
    end
    i_dsra_host.spi({1'b0, inc, a[5:0]}, 3, three);
    for (int k = 0; k < 3; k++)
    begin
      chk("spi write", mem[idx_at(a, inc, k)], sh[idx_at(a, inc, k)]);
    end
    i_dsra_host.spi({1'b1, inc, a[5:0]}, 3, three);
    for (int k = 0; k < 3; k++)
    begin
      chk("spi read", i_dsra_host.rbuf[k], sh[idx_at(a, inc, k)]);
    end
    $display("test spi three_wire=%0d inc=%0d done", three, inc);
  endtask

  task automatic tw_send(input logic [7:0] v, input logic want);
    logic ack;
    i_dsra_host.tw_tx(v, ack);
    chk("acknowledge", {7'h0, ack}, {7'h0, want});
  endtask

  // Two-wire burst write, burst read with repeated start, then a foreign address.
  task automatic tw_test(input logic strap);
    logic [6:0] a;
    logic [7:0] v;
    addr_select_pin = strap;
    three_wire_select = 1'b0;
    a = 7'($urandom_range(0, 100));
    i_dsra_host.tw_start();
    chk("busy after start", {7'h0, bus_busy}, 8'h01);
    tw_send(tw_addr(strap, 1'b0), 1'b1);
    tw_send({1'b1, a}, 1'b1);
    for (int k = 0; k < 2; k++)
    begin
      sh[a + 7'(k)] = 8'($urandom);
      tw_send(sh[a + 7'(k)], 1'b1);
    end
    i_dsra_host.tw_stop();
    chk("busy after stop", {7'h0, bus_busy}, 8'h00);
    for (int k = 0; k < 2; k++) chk("two-wire write", mem[a + 7'(k)], sh[a + 7'(k)]);
    i_dsra_host.tw_start();
    tw_send(tw_addr(strap, 1'b0), 1'b1);
    tw_send({1'b1, a}, 1'b1);
    i_dsra_host.tw_start();
    tw_send(tw_addr(strap, 1'b1), 1'b1);
    i_dsra_host.tw_rx(1'b0, v);
    chk("two-wire read", v, sh[a]);
    i_dsra_host.tw_rx(1'b1, v);
    chk("two-wire read", v, sh[a + 7'h1]);
    i_dsra_host.tw_stop();
    i_dsra_host.tw_start();
    tw_send(tw_addr(!strap, 1'b0), 1'b0);
    i_dsra_host.tw_stop();
    chk("stretch limit", 8'(i_dsra_host.stall_outs), 8'h00);
    $display("test two-wire strap=%0d done", strap);
  endtask

  // Main sequence.
  initial
  begin
    arst_n = 1'b0;
    addr_select_pin = 1'b0;
    three_wire_select = 1'b0;
    reg_rdata = 8'h00;
    void'($urandom(74420));
    for (int i = 0; i < 128; i++)
    begin
      mem[i] = 8'($urandom);
      sh[i] = mem[i];
    end
    repeat (16) @(negedge sys_clk);
    chk("outputs in reset", {2'h0, bus_busy, serial_out_line_oe, serial_in_line_oe,
      serial_port_clock_oe, reg_wr_stb, reg_rd_stb}, 8'h00);
    arst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    for (int m = 0; m < 4; m++) spi_test(m[1], m[0]);
    tw_test(1'b0);
    tw_test(1'b1);
    results();
  end

  // Watchdog well beyond the expected run length.
  initial
  begin
    #(60000 * 40);
    fails++;
    results();
  end
endmodule

bind dsra_top dsra_chk i_dsra_chk (.sys_clk(sys_clk), .arst_n(arst_n),
  .chip_select_n(chip_select_n), .serial_port_clock_i(serial_port_clock_i),
  .serial_port_clock_o(serial_port_clock_o), .serial_port_clock_oe(serial_port_clock_oe),
  .serial_in_line_i(serial_in_line_i), .serial_in_line_o(serial_in_line_o),
  .serial_in_line_oe(serial_in_line_oe), .serial_out_line_oe(serial_out_line_oe),
  .three_wire_select(three_wire_select), .reg_wr_stb(reg_wr_stb),
  .reg_rd_stb(reg_rd_stb), .bus_busy(bus_busy));
`default_nettype wire
